// ==== src/dsd_data_space_decoder.sv ====
`timescale 1ns/100ps
module dsd_data_space_decoder
   import dsd_pkg::*;
(
   input  wire logic               REF_CLK,         // System clock
   input  wire logic               RST,             // Async reset, high
   // Core data bus
   input  wire logic               DB_VALID,        // Access this cycle
   input  wire logic [ADDR_W-1:0]  DB_ADDR,         // Word address
   input  wire logic               DB_LONG,         // Long-word access
   input  wire logic               DB_WRITE,        // Write access
   input  wire logic [LONG_W-1:0]  DB_WDATA,        // Write data
   output logic      [LONG_W-1:0]  DB_RDATA,        // Data RAM read data
   input  wire logic [MODE_REG_W-1:0] CORE_MODE_REG, // Operating mode reg
   output logic                    SEL_DEBUG,       // Debug unit
   output logic                    SEL_PERIPH,      // Peripherals
   output logic                    SEL_DRAM,        // On-chip data RAM
   output logic                    SEL_DFLASH,      // On-chip data flash
   output logic                    SEL_EXT,         // External memory
   output logic                    PERIPH_SIZE_ERR, // Long peripheral hit
   output logic [SECT_W-1:0]       DF_SECTOR,       // Data flash sector
   output logic [SECT_W-1:0]       DF_PAGE,         // Data flash page
   output logic                    DATA_BANK_SEL,   // Data flash bank
   // Program bus flash decode
   input  wire logic               PB_VALID,        // Program access
   input  wire logic [PADDR_W-1:0] PB_ADDR,         // Program word addr
   output logic                    SEL_PFLASH,      // Program flash
   output logic                    SEL_BOOT,        // Boot flash
   output logic                    PROG_BANK_SEL,   // Shared bank set
   output logic [SECT_W-1:0]       PB_SECTOR,       // Sector in bank
   output logic [PAGE_W-1:0]       PB_PAGE,         // Page in bank
   // Vector fetch
   input  wire logic [VBASE_W-1:0] VECTOR_BASE,     // Vector base
   input  wire logic [VNUM_W-1:0]  VEC_NUM,         // Vector number
   output logic      [PADDR_W-1:0] VEC_ENTRY_ADDR,  // First entry word
   input  wire logic               VEC_DATA_VALID,  // Entry words valid
   input  wire logic [WORD_W-1:0]  VEC_WORD_LO,     // First entry word
   input  wire logic [WORD_W-1:0]  VEC_WORD_HI,     // Second entry word
   output logic      [VTGT_W-1:0]  VEC_TARGET,      // Program target
   output logic                    VEC_TARGET_VALID, // Target pulse
   output logic                    VEC_IS_RESET,    // Reset address
   // Flash configuration load
   output logic                    CFG_RD_REQ,      // Flash read request
   output logic      [PADDR_W-1:0] CFG_RD_ADDR,     // Flash word address
   input  wire logic               CFG_RD_ACK,      // Read data present
   input  wire logic [WORD_W-1:0]  CFG_RD_DATA,     // Flash word
   output logic                    CFG_WE,          // Config write pulse
   output logic      [3:0]         CFG_IDX,         // Config register
   output logic      [WORD_W-1:0]  CFG_DATA,        // Config value
   output logic                    INIT_DONE        // Load complete
);

   ////////////////////////////////////////////////////////////////////////
   // Data space decode
   dsd_region_t       region;               // Region of DB_ADDR
   logic              offchip_layout_bit;   // External low layout
   logic [ADDR_W-1:0] df_off;               // Offset in data flash

   // Mode bit straight from the core register
   assign offchip_layout_bit = CORE_MODE_REG[OFFCHIP_BIT];

   // Priority walk from the top of data space; addresses are word
   // addresses throughout, so no byte lane bits are dropped
   always_comb begin
      region = DSD_R_EXT;
      if (DB_ADDR >= DEBUG_BASE) begin
         region = DSD_R_DEBUG;
      end else if (DB_ADDR >= PERIPH_BASE && DB_ADDR <= PERIPH_LAST) begin
         region = DSD_R_PERIPH;
      end else if (!offchip_layout_bit && DB_ADDR <= DRAM_LAST) begin
         region = DSD_R_DRAM;
      end else if (!offchip_layout_bit && DB_ADDR >= DFLASH_BASE &&
                   DB_ADDR <= DFLASH_LAST) begin
         region = DSD_R_DFLASH;
      end
   end

   // One select per valid cycle, no register in the path
   assign SEL_DEBUG  = DB_VALID && (region == DSD_R_DEBUG);
   assign SEL_PERIPH = DB_VALID && (region == DSD_R_PERIPH);
   assign SEL_DRAM   = DB_VALID && (region == DSD_R_DRAM);
   assign SEL_DFLASH = DB_VALID && (region == DSD_R_DFLASH);
   assign SEL_EXT    = DB_VALID && (region == DSD_R_EXT);

   // Data flash has its own bank and partition
   assign df_off        = DB_ADDR - DFLASH_BASE;
   assign DF_SECTOR     = SECT_W'(df_off >> DF_SECT_SH);
   assign DF_PAGE       = SECT_W'(df_off >> DF_PAGE_SH);
   assign DATA_BANK_SEL = SEL_DFLASH;

   ////////////////////////////////////////////////////////////////////////
   // Program bus flash decode
   logic [PADDR_W-1:0] bf_off;              // Offset in boot flash

   assign bf_off        = PB_ADDR - BOOT_BASE;
   assign SEL_PFLASH    = PB_VALID && (PB_ADDR <= PFLASH_LAST);
   assign SEL_BOOT      = PB_VALID && (PB_ADDR >= BOOT_BASE) &&
                          (PB_ADDR <= BOOT_LAST);
   // Program and boot flash share one register bank
   assign PROG_BANK_SEL = SEL_PFLASH || SEL_BOOT;

   // Sector and page for whichever program-side bank is hit
   always_comb begin
      PB_SECTOR = '0;
      PB_PAGE   = '0;
      if (SEL_PFLASH) begin
         PB_SECTOR = SECT_W'(PB_ADDR >> PF_SECT_SH);
         PB_PAGE   = PAGE_W'(PB_ADDR >> PF_PAGE_SH);
      end else if (SEL_BOOT) begin
         PB_SECTOR = SECT_W'(bf_off >> BF_SECT_SH);
         PB_PAGE   = PAGE_W'(bf_off >> BF_PAGE_SH);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Data RAM, one long word per entry
   logic [DRAM_AW-1:0] ram_index;           // Entry of the word pair

   // Word address bit 0 picks the half; bits DRAM_AW down to 1 pick the entry
   assign ram_index = DB_ADDR[DRAM_AW:1];

   dsd_word_ram #(
      .DEPTH   (DRAM_DEPTH),
      .AW      (DRAM_AW)
   ) u_ram (
      .clk     (REF_CLK),
      .rst     (RST),
      .en      (SEL_DRAM),
      .we      (DB_WRITE),
      .is_long (DB_LONG),
      .upper   (DB_ADDR[0]),
      .index   (ram_index),
      .wdata   (DB_WDATA),
      .rdata   (DB_RDATA)
   );

   ////////////////////////////////////////////////////////////////////////
   // Access size check on peripherals; one-cycle pulse
   logic size_err_d;                        // Next error pulse
   logic size_err_q;                        // Error pulse register

   // A long access cannot be split safely in a peripheral
   always_comb begin
      size_err_d = SEL_PERIPH && DB_LONG;
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         size_err_q <= 1'b0;
      end else begin
         size_err_q <= size_err_d;
      end
   end

   assign PERIPH_SIZE_ERR = size_err_q;

   ////////////////////////////////////////////////////////////////////////
   // Vector fetch
   logic [VTGT_W-1:0] vtgt_d;               // Next target
   logic [VTGT_W-1:0] vtgt_q;               // Target register
   logic              vvld_d;               // Next target pulse
   logic              vvld_q;               // Target pulse register
   logic              vrst_d;               // Next reset flag
   logic              vrst_q;               // Reset flag register

   // Entries are two words apart, so number shifts by one
   assign VEC_ENTRY_ADDR = {VECTOR_BASE, VEC_NUM, 1'b0};

   // Only the low bits of the second word count
   always_comb begin
      vtgt_d = vtgt_q;
      vrst_d = vrst_q;
      vvld_d = VEC_DATA_VALID;
      if (VEC_DATA_VALID) begin
         vtgt_d = {VEC_WORD_HI[VHI_W-1:0], VEC_WORD_LO};
         vrst_d = (VECTOR_BASE == RESET_VBASE) &&
                  (VEC_NUM < RESET_ENTRIES);
      end
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         vtgt_q <= '0;
         vvld_q <= 1'b0;
         vrst_q <= 1'b0;
      end else begin
         vtgt_q <= vtgt_d;
         vvld_q <= vvld_d;
         vrst_q <= vrst_d;
      end
   end

   assign VEC_TARGET       = vtgt_q;
   assign VEC_TARGET_VALID = vvld_q;
   assign VEC_IS_RESET     = vrst_q;

   ////////////////////////////////////////////////////////////////////////
   // Configuration load after reset
   typedef enum {DSD_S_LOAD, DSD_S_DONE} dsd_init_t;

   dsd_init_t          st_d;                // Next state
   dsd_init_t          st_q;                // Load state
   logic [PADDR_W-1:0] addr_d;              // Next flash address
   logic [PADDR_W-1:0] addr_q;              // Flash address
   logic [3:0]         idx_d;               // Next config index
   logic [3:0]         idx_q;               // Config index
   logic               we_d;                // Next write pulse
   logic               we_q;                // Write pulse
   logic [WORD_W-1:0]  data_d;              // Next config value
   logic [WORD_W-1:0]  data_q;              // Config value
   logic [3:0]         cidx_d;              // Next written index
   logic [3:0]         cidx_q;              // Written index

   // Walk the nine top words, one per acknowledge
   always_comb begin
      st_d   = st_q;
      addr_d = addr_q;
      idx_d  = idx_q;
      cidx_d = cidx_q;
      data_d = data_q;
      we_d   = 1'b0;
      case (st_q)
         DSD_S_LOAD: begin
            if (CFG_RD_ACK) begin
               we_d   = 1'b1;
               data_d = CFG_RD_DATA;
               cidx_d = idx_q;
               idx_d  = idx_q + 4'h1;
               addr_d = addr_q + 21'h000001;
               if (idx_q == CFG_COUNT - 4'h1) begin
                  st_d = DSD_S_DONE;
               end
            end
         end
         DSD_S_DONE: begin
            st_d = DSD_S_DONE;
         end
         default: begin
            st_d = DSD_S_LOAD;
         end
      endcase
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         st_q   <= DSD_S_LOAD;
         addr_q <= CFG_FIRST;
         idx_q  <= '0;
         cidx_q <= '0;
         we_q   <= 1'b0;
         data_q <= '0;
      end else begin
         st_q   <= st_d;
         addr_q <= addr_d;
         idx_q  <= idx_d;
         cidx_q <= cidx_d;
         we_q   <= we_d;
         data_q <= data_d;
      end
   end

   assign CFG_RD_REQ  = (st_q == DSD_S_LOAD);
   assign CFG_RD_ADDR = addr_q;
   assign CFG_WE      = we_q;
   assign CFG_IDX     = cidx_q;
   assign CFG_DATA    = data_q;
   assign INIT_DONE   = (st_q == DSD_S_DONE) && !we_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);

   logic [3:0] wr_cnt_q;                    // Config writes seen
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         wr_cnt_q <= '0;
      end else if (CFG_WE) begin
         wr_cnt_q <= wr_cnt_q + 4'h1;
      end
   end

   property p_onehot;
      DB_VALID |-> $onehot({SEL_DEBUG, SEL_PERIPH, SEL_DRAM,
                             SEL_DFLASH, SEL_EXT});
   endproperty
   a_onehot: assert property (p_onehot)
      else $error("Region selects not one-hot");

   property p_debug;
      DB_VALID && DB_ADDR >= DEBUG_BASE |-> SEL_DEBUG;
   endproperty
   a_debug: assert property (p_debug)
      else $error("Debug window not selected");

   property p_periph;
      DB_VALID && DB_ADDR >= PERIPH_BASE && DB_ADDR <= PERIPH_LAST
         |-> SEL_PERIPH;
   endproperty
   a_periph: assert property (p_periph)
      else $error("Peripheral window not selected");

   property p_low_onchip;
      DB_VALID && !CORE_MODE_REG[OFFCHIP_BIT] && DB_ADDR <= DRAM_LAST
         |-> SEL_DRAM && !SEL_EXT;
   endproperty
   a_low_onchip: assert property (p_low_onchip)
      else $error("Low data RAM not selected");

   property p_low_ext;
      DB_VALID && CORE_MODE_REG[OFFCHIP_BIT] && DB_ADDR <= DFLASH_LAST
         |-> SEL_EXT;
   endproperty
   a_low_ext: assert property (p_low_ext)
      else $error("Low space not external with mode bit set");

   property p_long_ram;
      (SEL_DRAM && DB_WRITE && DB_LONG) ##1
      (SEL_DRAM && !DB_WRITE && DB_LONG && $stable(DB_ADDR))
         |=> DB_RDATA == $past(DB_WDATA, 2);
   endproperty
   a_long_ram: assert property (p_long_ram)
      else $error("Long word not returned whole");

   property p_vec_target;
      VEC_DATA_VALID |=> VEC_TARGET_VALID &&
         VEC_TARGET == {$past(VEC_WORD_HI[VHI_W-1:0]), $past(VEC_WORD_LO)};
   endproperty
   a_vec_target: assert property (p_vec_target)
      else $error("Vector target wrong");

   property p_vec_reset;
      VEC_DATA_VALID && VECTOR_BASE == RESET_VBASE &&
      VEC_NUM < RESET_ENTRIES
         |=> VEC_IS_RESET;
   endproperty
   a_vec_reset: assert property (p_vec_reset)
      else $error("Reset entry not flagged");

   property p_cfg_count;
      INIT_DONE |-> wr_cnt_q == CFG_COUNT;
   endproperty
   a_cfg_count: assert property (p_cfg_count)
      else $error("Config load count wrong");

   property p_size_err;
      SEL_PERIPH && DB_LONG |=> PERIPH_SIZE_ERR;
   endproperty
   a_size_err: assert property (p_size_err)
      else $error("Long peripheral access not flagged");

   property p_banks;
      PB_VALID && PB_ADDR >= BOOT_BASE && PB_ADDR <= BOOT_LAST
         |-> PROG_BANK_SEL && !SEL_PFLASH;
   endproperty
   a_banks: assert property (p_banks)
      else $error("Boot flash bank not selected");

   c_ext_mode: cover property (SEL_EXT && DB_ADDR <= DRAM_LAST);
   c_init:     cover property (CFG_WE ##1 INIT_DONE);
   c_reset_v:  cover property (VEC_IS_RESET && VEC_TARGET_VALID);
   c_err:      cover property (PERIPH_SIZE_ERR);

endmodule

// ==== src/dsd_pkg.sv ====
// Shared constants for the data space decoder
package dsd_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Data bus widths (word addresses, 16-bit words)
   localparam int ADDR_W    = 24;           // Data word address width
   localparam int WORD_W    = 16;           // One data word
   localparam int LONG_W    = 32;           // Long word, two data words
   localparam int PADDR_W   = 21;           // Program word address width

   ////////////////////////////////////////////////////////////////////////
   // Data space regions
   localparam logic [23:0] DEBUG_BASE   = 24'hFFFF00; // Top 256 words
   localparam logic [23:0] PERIPH_BASE  = 24'h00F000; // 4096-word window
   localparam logic [23:0] PERIPH_LAST  = 24'h00FFFF;
   localparam logic [23:0] DRAM_LAST    = 24'h001FFF; // 16KB window; the 8KB data RAM appears twice in it
   localparam logic [23:0] DFLASH_BASE  = 24'h002000; // 8KB data flash
   localparam logic [23:0] DFLASH_LAST  = 24'h002FFF;

   // Operating mode register bit that picks the external low layout
   localparam int MODE_REG_W  = 16;
   localparam int OFFCHIP_BIT = 3;

   ////////////////////////////////////////////////////////////////////////
   // Data RAM shape: 2K entries of one long word each
   localparam int DRAM_DEPTH = 2048;
   localparam int DRAM_AW    = 11;

   ////////////////////////////////////////////////////////////////////////
   // Vector table
   localparam int VBASE_W    = 13;          // Vector base register width
   localparam int VNUM_W     = 7;           // Vector number width
   localparam int VTGT_W     = 19;          // Reach of one vector entry
   localparam int VHI_W      = VTGT_W - WORD_W; // Bits from second word
   localparam logic [12:0] RESET_VBASE   = 13'h0200; // Power-on location
   localparam logic [6:0]  RESET_ENTRIES = 7'h02;    // Reset address slots

   ////////////////////////////////////////////////////////////////////////
   // Program flash, boot flash and configuration words
   localparam logic [20:0] PFLASH_LAST = 21'h01FFFF;
   localparam logic [20:0] BOOT_BASE   = 21'h020000;
   localparam logic [20:0] BOOT_LAST   = 21'h021FFF;
   localparam logic [20:0] CFG_FIRST   = 21'h01FFF7;
   localparam logic [3:0]  CFG_COUNT   = 4'h9;  // Nine configuration words

   // Flash partitions, as shifts of the word offset
   localparam int PF_SECT_SH = 13;          // 8K-word sectors
   localparam int PF_PAGE_SH = 9;           // 512-word pages
   localparam int DF_SECT_SH = 8;           // 256-word sectors
   localparam int DF_PAGE_SH = 8;           // 256-word pages
   localparam int BF_SECT_SH = 11;          // 2K-word sectors
   localparam int BF_PAGE_SH = 8;           // 256-word pages
   localparam int SECT_W     = 4;
   localparam int PAGE_W     = 8;

   // Data space region codes
   typedef enum {DSD_R_DRAM, DSD_R_DFLASH, DSD_R_PERIPH, DSD_R_DEBUG,
                 DSD_R_EXT} dsd_region_t;

endpackage

// ==== src/dsd_word_ram.sv ====
`timescale 1ns/100ps
// Long-word data RAM; each entry holds two data words
module dsd_word_ram
   import dsd_pkg::*;
#(
   parameter int DEPTH = DRAM_DEPTH,        // Entries
   parameter int AW    = DRAM_AW            // Entry index width
) (
   input  wire logic              clk,      // System clock
   input  wire logic              rst,      // Async reset, high
   input  wire logic              en,       // Access strobe
   input  wire logic              we,       // Write access
   input  wire logic              is_long,  // Long-word access
   input  wire logic              upper,    // Word in upper half
   input  wire logic [AW-1:0]     index,    // Entry index
   input  wire logic [LONG_W-1:0] wdata,    // Write data
   output logic      [LONG_W-1:0] rdata     // Registered read data
);

   ////////////////////////////////////////////////////////////////////////
   logic [LONG_W-1:0] mem [DEPTH];          // Storage, no reset
   logic [LONG_W-1:0] rdata_d;              // Next read data
   logic [LONG_W-1:0] rdata_q;              // Read data register
   logic [LONG_W-1:0] entry;                // Addressed entry

   assign entry = mem[index];
   assign rdata = rdata_q;

   // Pick long or one half; half reads in the low bits
   always_comb begin
      rdata_d = rdata_q;
      if (en && !we) begin
         if (is_long) begin
            rdata_d = entry;
         end else if (upper) begin
            rdata_d = {{WORD_W{1'b0}}, entry[LONG_W-1:WORD_W]};
         end else begin
            rdata_d = {{WORD_W{1'b0}}, entry[WORD_W-1:0]};
         end
      end
   end

   // Whole entry in one cycle for a long write
   always_ff @(posedge clk) begin
      if (en && we && (is_long || !upper)) begin
         mem[index][WORD_W-1:0] <= wdata[WORD_W-1:0];
      end
      if (en && we && is_long) begin
         mem[index][LONG_W-1:WORD_W] <= wdata[LONG_W-1:WORD_W];
      end else if (en && we && upper) begin
         mem[index][LONG_W-1:WORD_W] <= wdata[WORD_W-1:0];
      end
   end

   // Read register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

endmodule

// ==== tb/dsd_flash_model.sv ====
`timescale 1ns/100ps
// Flash array model answering configuration word reads
module dsd_flash_model
   import dsd_pkg::*;
(
   input  wire logic               clk,  // System clock
   input  wire logic               rst,  // Async reset, high
   input  wire logic               req,  // Read request
   input  wire logic [PADDR_W-1:0] addr, // Word address
   output logic                    ack,  // Read data present
   output logic      [WORD_W-1:0]  data  // Read word
);
   logic [2:0] pace_q; // Stall pattern counter
   ////////////////////////////////////////////////////////////////////////
   // Free running pace, so answers come both back to back and late
   always_ff @(posedge clk or posedge rst) begin
      if (rst) pace_q <= 3'h0;
      else pace_q <= pace_q + 3'h1;
   end
   // No answer while in reset or on stall slots
   assign ack = req && !rst && pace_q != 3'h2 && pace_q != 3'h5;
   // Idle lines show the inverse, never a stale copy of the word
   assign data = ack ? (addr[15:0] ^ 16'hC3A5) : ~(addr[15:0] ^ 16'hC3A5);
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/100ps
// Self-checking bench for the data space decoder
`define CHK(w,e,s) begin checks_done++; if ((e) !== (s)) begin errors++; \
   $display("unexpected %s exp %0h got %0h", w, e, s); end end
module tb
   import dsd_pkg::*;
;
   logic REF_CLK, RST, DB_VALID, DB_LONG, DB_WRITE, PB_VALID;
   logic VEC_DATA_VALID, CFG_RD_ACK, SEL_DEBUG, SEL_PERIPH, SEL_DRAM;
   logic SEL_DFLASH, SEL_EXT, PERIPH_SIZE_ERR, DATA_BANK_SEL, SEL_PFLASH;
   logic SEL_BOOT, PROG_BANK_SEL, VEC_TARGET_VALID, VEC_IS_RESET;
   logic CFG_RD_REQ, CFG_WE, INIT_DONE;
   logic [23:0] DB_ADDR;
   logic [31:0] DB_WDATA, DB_RDATA, rs;
   logic [15:0] CORE_MODE_REG, VEC_WORD_LO, VEC_WORD_HI, CFG_RD_DATA;
   logic [15:0] CFG_DATA;
   logic [3:0]  DF_SECTOR, DF_PAGE, PB_SECTOR, CFG_IDX;
   logic [7:0]  PB_PAGE;
   logic [20:0] PB_ADDR, VEC_ENTRY_ADDR, CFG_RD_ADDR, off;
   logic [12:0] VECTOR_BASE;
   logic [6:0]  VEC_NUM;
   logic [18:0] VEC_TARGET;
   logic [31:0] exp_q[$]; // Expected results, oldest first
   int errors, checks_done, cyc;
   logic [23:0] tbl[12] = '{24'h000000, 24'h001FFF, 24'h002000, 24'h002FFF,
      24'h003000, 24'h00EFFF, 24'h00F000, 24'h00FFFF, 24'h010000,
      24'hFFFEFF, 24'hFFFF00, 24'hFFFFFF}; // Region boundaries
   logic [20:0] ptbl[6] = '{21'h000000, 21'h01FFFF, 21'h00A3C1,
      21'h020000, 21'h021FFF, 21'h022000}; // Program bank edges

   dsd_data_space_decoder DUT (.*);
   dsd_flash_model u_flash (.clk(REF_CLK), .rst(RST), .req(CFG_RD_REQ),
      .addr(CFG_RD_ADDR), .ack(CFG_RD_ACK), .data(CFG_RD_DATA));

   ////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   initial begin
      REF_CLK = 1'b0;
      forever #10 REF_CLK = ~REF_CLK;
   end
   always @(posedge REF_CLK) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         summarize();
      end
   end
   // Result watcher: a pulse takes the oldest note off the queue
   always @(negedge REF_CLK) begin
      if (CFG_WE === 1'b1 || VEC_TARGET_VALID === 1'b1) begin
         `CHK("pending", 1, exp_q.size() > 0)
         if (exp_q.size() > 0 && CFG_WE === 1'b1)
            `CHK("cfg", exp_q.pop_front(), {12'h0, CFG_IDX, CFG_DATA})
         else if (exp_q.size() > 0)
            `CHK("vec", exp_q.pop_front(), {12'h0, VEC_IS_RESET, VEC_TARGET})
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   // One-hot {debug, periph, ram, dflash, ext} for a word address
   function automatic logic [4:0] reg_exp(logic [23:0] a, logic ex);
      if (a >= 24'hFFFF00) return 5'h10;
      if (a >= 24'h00F000 && a <= 24'h00FFFF) return 5'h08;
      if (!ex && a <= 24'h001FFF) return 5'h04;
      if (!ex && a >= 24'h002000 && a <= 24'h002FFF) return 5'h02;
      return 5'h01;
   endfunction
   // Data bus access launched at the falling edge
   task automatic bus(logic [23:0] a, logic lg, logic wr, logic [31:0] d);
      @(negedge REF_CLK);
      DB_VALID = 1'b1;
      DB_ADDR = a;
      DB_LONG = lg;
      DB_WRITE = wr;
      DB_WDATA = d;
   endtask
   task automatic dec(logic [23:0] a, logic ex);
      logic [4:0] e;
      e = reg_exp(a, ex);
      bus(a, 1'b0, 1'b0, xs());
      CORE_MODE_REG = xs();
      CORE_MODE_REG[3] = ex;
      #2;
      `CHK("sel", e, {SEL_DEBUG, SEL_PERIPH, SEL_DRAM, SEL_DFLASH, SEL_EXT})
      `CHK("dfbank", e[1], DATA_BANK_SEL)
      if (e[1]) `CHK("dfsect", {a[11:8], a[11:8]}, {DF_SECTOR, DF_PAGE})
   endtask
   task summarize;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rs = 32'hD96D;
      {RST, DB_VALID, DB_LONG, DB_WRITE, PB_VALID, VEC_DATA_VALID} = 6'h20;
      {DB_ADDR, DB_WDATA, CORE_MODE_REG, PB_ADDR} = '0;
      {VECTOR_BASE, VEC_NUM, VEC_WORD_LO, VEC_WORD_HI} = '0;
      for (int i = 0; i < 9; i++)
         exp_q.push_back({12'h0, 4'(i), 16'(21'h01FFF7 + i) ^ 16'hC3A5});
      repeat (2) @(posedge REF_CLK);
      @(negedge REF_CLK) RST = 1'b0;
      // Configuration load with a stalling flash
      for (int i = 0; i < 100 && INIT_DONE !== 1'b1; i++) @(negedge REF_CLK);
      `CHK("done", 1'b1, INIT_DONE)
      `CHK("left", 0, exp_q.size())
      $display("test cfg done");
      // Region decode in both layouts, edges and random addresses
      for (int ex = 0; ex < 2; ex++) begin
         foreach (tbl[i]) dec(tbl[i], ex[0]);
         for (int i = 0; i < 8; i++) begin
            rs = xs();
            dec(rs[0] ? {8'h0, rs[23:8]} : rs[23:0], ex[0]);
         end
      end
      @(negedge REF_CLK) DB_VALID = 1'b0;
      #2 `CHK("idle", 5'h0, {SEL_DEBUG, SEL_PERIPH, SEL_DRAM, SEL_DFLASH, SEL_EXT})
      $display("test decode done");
      // Long and word accesses to the data RAM, back to back
      CORE_MODE_REG = 16'h0000;
      bus(24'h000010, 1'b1, 1'b1, 32'hA1B2C3D4);
      bus(24'h000010, 1'b1, 1'b0, 32'h0);
      bus(24'h000012, 1'b1, 1'b1, 32'h11112222);
      bus(24'h000013, 1'b0, 1'b1, 32'h00005A5A);
      bus(24'h000012, 1'b1, 1'b0, 32'h0);
      bus(24'h000011, 1'b1, 1'b0, 32'h0);
      `CHK("ram", 32'h5A5A2222, DB_RDATA)
      bus(24'h00F123, 1'b1, 1'b0, 32'h0);
      `CHK("ram", 32'hA1B2C3D4, DB_RDATA)
      bus(24'h00F123, 1'b0, 1'b0, 32'h0);
      `CHK("perr", 1'b1, PERIPH_SIZE_ERR)
      @(negedge REF_CLK) DB_VALID = 1'b0;
      `CHK("perr", 1'b0, PERIPH_SIZE_ERR)
      $display("test ram done");
      // Vector entries, back to back, at and away from the reset base
      for (int i = 0; i < 5; i++) begin
         @(negedge REF_CLK);
         VEC_DATA_VALID = 1'b1;
         VECTOR_BASE = (i < 4) ? 13'h0200 : 13'h0001;
         VEC_NUM = (i < 4) ? 7'(i) : 7'h00;
         {VEC_WORD_HI, VEC_WORD_LO} = xs();
         exp_q.push_back({12'h0, VECTOR_BASE == 13'h0200 && i < 2,
            VEC_WORD_HI[2:0], VEC_WORD_LO});
         #2 `CHK("vaddr", {VECTOR_BASE, VEC_NUM, 1'b0}, VEC_ENTRY_ADDR)
      end
      @(negedge REF_CLK) VEC_DATA_VALID = 1'b0;
      @(negedge REF_CLK) `CHK("vleft", 0, exp_q.size())
      $display("test vector done");
      // Program bus banks
      for (int i = 0; i < 7; i++) begin
         @(negedge REF_CLK);
         PB_VALID = (i < 6);
         PB_ADDR = (i < 6) ? ptbl[i] : 21'h000000;
         off = PB_ADDR - 21'h020000;
         #2;
         if (PB_VALID && PB_ADDR <= 21'h01FFFF)
            `CHK("pb", {4'hA, PB_ADDR[16:13], PB_ADDR[16:9]}, {SEL_PFLASH, SEL_BOOT, PROG_BANK_SEL, 1'b0, PB_SECTOR, PB_PAGE})
         else if (PB_VALID && PB_ADDR <= 21'h021FFF)
            `CHK("pb", {4'h6, 2'h0, off[12:11], 3'h0, off[12:8]}, {SEL_PFLASH, SEL_BOOT, PROG_BANK_SEL, 1'b0, PB_SECTOR, PB_PAGE})
         else
            `CHK("pb", 16'h0, {SEL_PFLASH, SEL_BOOT, PROG_BANK_SEL, 1'b0, PB_SECTOR, PB_PAGE})
      end
      $display("test program done");
      summarize();
   end
endmodule
